// ===== pps_map.svh
// Register offsets, field positions, reset values and timing counts for the pump sequencer
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PPS_CTRL_OFS 8'h00
`define PPS_VOL_OFS 8'h04
`define PPS_STAT_OFS 8'h08
`define PPS_FILL_OFS 8'h0C
`define PPS_DLV_OFS 8'h10
`define PPS_TOT_OFS 8'h14

// ****************************************
// Field positions
// ****************************************
`define PPS_CTRL_TRIG_BIT 0
`define PPS_STAT_BUSY_BIT 0
`define PPS_STAT_DIR_BIT 1
`define PPS_STAT_RUN_BIT 2
`define PPS_STAT_LIQ_BIT 3
`define PPS_STAT_STATE_LSB 4

// ****************************************
// Reset values and timing
// ****************************************
`define PPS_VOL_RST 32'h0000_0000
`define PPS_CLK_HZ 125000000
`define PPS_RELAY_MS 20
`define PPS_PURGE_PULSES 200
`define PPS_PPR 10

`endif

// ===== pps_pkg.sv
// Types shared by the pump sequencer files
package pps_pkg;

  // Sequencer states, Gray codes along the usual path except the two-bit DONE to IDLE return
  typedef enum logic [3:0] {
    PPS_IDLE = 4'b0000,
    PPS_PRE_SET = 4'b0001,
    PPS_PRE_RUN = 4'b0011,
    PPS_FILL_SET = 4'b0010,
    PPS_FILL_RUN = 4'b0110,
    PPS_DLV_RUN = 4'b0111,
    PPS_POST_SET = 4'b0101,
    PPS_POST_RUN = 4'b0100,
    PPS_DONE = 4'b1100
  } pps_state_t;

  // Motor drive outputs travel together
  typedef struct packed {
    logic dir_fwd;
    logic run;
    logic sensor_pwr;
  } pps_drive_t;

endpackage

// ===== pps_pulse_cnt.sv
// Revolution pulse edge detector and counter
`timescale 1ns/10ps

module pps_pulse_cnt #(
  parameter int CW = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic pulse_i,
  // Result
  output logic edge_o,
  output logic [CW-1:0] count_o
);

  logic prev_reg;
  logic prev_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // Count rising edges only while the sensor is powered
  always_comb begin
    // Held high while unpowered, so a sensor waking mid-pulse gives no false edge
    prev_next = en_i ? pulse_i : 1'b1;
    edge_o = en_i && pulse_i && !prev_reg;
    cnt_next = cnt_reg;
    if (clr_i) begin
      cnt_next = '0;
    end else if (edge_o) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b1;
      cnt_reg <= '0;
    end else begin
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
    end
  end

  assign count_o = cnt_reg;

endmodule

// ===== pps_sequencer.sv
// Peristaltic pump sample-event sequencer with Wishbone registers
`timescale 1ns/10ps
`include "pps_map.svh"

// Functional notes
// - Direction output low means relay at rest and reverse pumping, high means forward.
// - Each run sets direction, waits the relay settle time, then raises motor run.
// - The revolution sensor is powered exactly while motor run is active.
// - Each sensor pulse is counted and the count measures pumped volume.
// - Pulses convert to rotor revolutions by a constant pulses-per-revolution factor.
// - A sample event starts with a reverse purge.
// - After the pre-purge the pump turns forward to fill the line.
// - Fill revolutions are counted and at liquid detection the delivery count is computed.
// - The pump keeps forward until the computed delivery count is reached.
// - After delivery the pump purges in reverse and then motor run drops.
// - After stopping the sequencer idles until the next trigger, restarting at pre-purge.
module pps_sequencer #(
  parameter int RELAY_CYC = (`PPS_CLK_HZ / 1000) * `PPS_RELAY_MS,
  parameter int PURGE_PULSES = `PPS_PURGE_PULSES,
  parameter int PPR = `PPS_PPR
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Host event side
  input wire logic trigger_i,
  output logic done_o,
  output logic busy_o,
  // Pump board
  input wire logic liquid_i,
  input wire logic rev_pulse_i,
  output logic direction_relay_o,
  output logic motor_run_o,
  output logic sensor_pwr_o
);

  // ****************************************
  // Declarations
  // ****************************************
  pps_pkg::pps_state_t st_reg, st_next;
  pps_pkg::pps_drive_t drv_reg, drv_next;
  logic [31:0] wait_reg, wait_next;
  logic [31:0] vol_reg, vol_next;
  logic [31:0] fill_reg, fill_next;
  logic [31:0] dlv_reg, dlv_next;
  logic [31:0] tot_reg, tot_next;
  logic done_reg, done_next;
  logic busy_reg, busy_next;
  logic trig_reg, trig_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic cnt_clr;
  logic pulse_edge;
  logic [31:0] pulse_cnt;
  logic wb_req;
  logic [31:0] fill_revs;

  // ****************************************
  // Revolution pulse counter
  // ****************************************
  // count sensor pulses
  pps_pulse_cnt #(
    .CW(32)
  ) u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(cnt_clr),
    .en_i(drv_reg.sensor_pwr),
    .pulse_i(rev_pulse_i),
    .edge_o(pulse_edge),
    .count_o(pulse_cnt)
  );

  assign fill_revs = pulse_cnt / 32'(PPR);

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign wb_req = cyc_i && stb_i && !ack_reg;

  // One-wait answer; trigger bit is write-only, pulses a start
  always_comb begin
    ack_next = wb_req;
    rdat_next = 32'h0000_0000;
    vol_next = vol_reg;
    trig_next = 1'b0;
    if (wb_req && we_i) begin
      if (adr_i == `PPS_CTRL_OFS && sel_i[0]) begin
        trig_next = dat_i[`PPS_CTRL_TRIG_BIT];
      end
      if (adr_i == `PPS_VOL_OFS) begin
        for (int b = 0; b < 4; b++) begin
          if (sel_i[b]) begin
            vol_next[b*8 +: 8] = dat_i[b*8 +: 8];
          end
        end
      end
    end else if (wb_req) begin
      unique case (adr_i)
        `PPS_VOL_OFS: rdat_next = vol_reg;
        `PPS_STAT_OFS: begin
          rdat_next[`PPS_STAT_BUSY_BIT] = (st_reg != pps_pkg::PPS_IDLE);
          rdat_next[`PPS_STAT_DIR_BIT] = drv_reg.dir_fwd;
          rdat_next[`PPS_STAT_RUN_BIT] = drv_reg.run;
          rdat_next[`PPS_STAT_LIQ_BIT] = liquid_i;
          rdat_next[`PPS_STAT_STATE_LSB +: 4] = st_reg;
        end
        `PPS_FILL_OFS: rdat_next = fill_reg;
        `PPS_DLV_OFS: rdat_next = dlv_reg;
        `PPS_TOT_OFS: rdat_next = tot_reg;
        default: rdat_next = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      vol_reg <= `PPS_VOL_RST;
      trig_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      vol_reg <= vol_next;
      trig_reg <= trig_next;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Next state, drive and counters
  always_comb begin
    st_next = st_reg;
    drv_next = drv_reg;
    wait_next = wait_reg;
    fill_next = fill_reg;
    dlv_next = dlv_reg;
    tot_next = tot_reg;
    done_next = 1'b0;
    cnt_clr = 1'b0;
    if (pulse_edge) begin
      tot_next = tot_reg + 32'h0000_0001;
    end
    unique case (st_reg)
      pps_pkg::PPS_IDLE: begin
        if (trigger_i || trig_reg) begin
          drv_next.dir_fwd = 1'b0;
          wait_next = 32'(RELAY_CYC);
          st_next = pps_pkg::PPS_PRE_SET;
        end
      end
      pps_pkg::PPS_PRE_SET, pps_pkg::PPS_FILL_SET, pps_pkg::PPS_POST_SET: begin
        if (wait_reg > 32'h0000_0001) begin
          wait_next = wait_reg - 32'h0000_0001;
        end else begin
          drv_next.run = 1'b1;
          drv_next.sensor_pwr = 1'b1;
          cnt_clr = 1'b1;
          st_next = (st_reg == pps_pkg::PPS_PRE_SET) ? pps_pkg::PPS_PRE_RUN :
                    (st_reg == pps_pkg::PPS_FILL_SET) ? pps_pkg::PPS_FILL_RUN : pps_pkg::PPS_POST_RUN;
        end
      end
      pps_pkg::PPS_PRE_RUN: begin
        if (pulse_cnt >= 32'(PURGE_PULSES)) begin
          drv_next = '0;
          drv_next.dir_fwd = 1'b1;
          wait_next = 32'(RELAY_CYC);
          st_next = pps_pkg::PPS_FILL_SET;
        end
      end
      pps_pkg::PPS_FILL_RUN: begin
        if (liquid_i) begin
          fill_next = fill_revs;
          dlv_next = (vol_reg + fill_revs) * 32'(PPR);
          cnt_clr = 1'b1;
          st_next = pps_pkg::PPS_DLV_RUN;
        end
      end
      pps_pkg::PPS_DLV_RUN: begin
        if (pulse_cnt >= dlv_reg) begin
          drv_next = '0;
          wait_next = 32'(RELAY_CYC);
          st_next = pps_pkg::PPS_POST_SET;
        end
      end
      pps_pkg::PPS_POST_RUN: begin
        if (pulse_cnt >= 32'(PURGE_PULSES)) begin
          drv_next = '0;
          st_next = pps_pkg::PPS_DONE;
        end
      end
      pps_pkg::PPS_DONE: begin
        done_next = 1'b1;
        st_next = pps_pkg::PPS_IDLE;
      end
      default: begin
        drv_next = '0;
        st_next = pps_pkg::PPS_IDLE;
      end
    endcase
    // Busy registered from next state, so the pin comes straight off a flop
    busy_next = (st_next != pps_pkg::PPS_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= pps_pkg::PPS_IDLE;
      drv_reg <= '0;
      wait_reg <= 32'h0000_0000;
      fill_reg <= 32'h0000_0000;
      dlv_reg <= 32'h0000_0000;
      tot_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      drv_reg <= drv_next;
      wait_reg <= wait_next;
      fill_reg <= fill_next;
      dlv_reg <= dlv_next;
      tot_reg <= tot_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // high selects forward
  assign direction_relay_o = drv_reg.dir_fwd;
  assign motor_run_o = drv_reg.run;
  assign sensor_pwr_o = drv_reg.sensor_pwr;
  assign done_o = done_reg;
  assign busy_o = busy_reg;
  assign ack_o = ack_reg;
  assign dat_o = rdat_reg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_run_after_settle;
    // Direction must already have held for two edges; a settle under two cycles is not useful
    @(posedge clk_i) disable iff (rst_i) $rose(motor_run_o) |->
      direction_relay_o == $past(direction_relay_o, 1) && direction_relay_o == $past(direction_relay_o, 2);
  endproperty
  a_run_after_settle: assert property (p_run_after_settle) else $error("run rose without settle");

  property p_sensor_with_run;
    @(posedge clk_i) disable iff (rst_i) sensor_pwr_o == motor_run_o;
  endproperty
  a_sensor_with_run: assert property (p_sensor_with_run) else $error("sensor power differs from run");

  property p_dir_stable_running;
    @(posedge clk_i) disable iff (rst_i) motor_run_o && $past(motor_run_o) |-> $stable(direction_relay_o);
  endproperty
  a_dir_stable_running: assert property (p_dir_stable_running) else $error("direction changed while running");

  property p_pre_reverse;
    @(posedge clk_i) disable iff (rst_i) st_reg == pps_pkg::PPS_PRE_RUN |-> !direction_relay_o;
  endproperty
  a_pre_reverse: assert property (p_pre_reverse) else $error("pre-purge not reverse");

  property p_fill_forward;
    @(posedge clk_i) disable iff (rst_i) st_reg == pps_pkg::PPS_FILL_RUN |-> direction_relay_o && motor_run_o;
  endproperty
  a_fill_forward: assert property (p_fill_forward) else $error("fill not forward");

  property p_liquid_to_deliver;
    @(posedge clk_i) disable iff (rst_i) st_reg == pps_pkg::PPS_FILL_RUN && liquid_i |=> st_reg == pps_pkg::PPS_DLV_RUN;
  endproperty
  a_liquid_to_deliver: assert property (p_liquid_to_deliver) else $error("no delivery after liquid");

  property p_post_reverse;
    @(posedge clk_i) disable iff (rst_i) st_reg == pps_pkg::PPS_POST_RUN |-> !direction_relay_o;
  endproperty
  a_post_reverse: assert property (p_post_reverse) else $error("post-purge not reverse");

  property p_done_one;
    @(posedge clk_i) disable iff (rst_i) done_o |-> !motor_run_o ##1 !done_o;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done not a stopped single pulse");

  property p_idle_off;
    @(posedge clk_i) disable iff (rst_i) st_reg == pps_pkg::PPS_IDLE |-> !motor_run_o && !busy_o;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("motor on while idle");

  c_event: cover property (@(posedge clk_i) disable iff (rst_i) done_o);
  c_liquid: cover property (@(posedge clk_i) disable iff (rst_i) st_reg == pps_pkg::PPS_DLV_RUN);
  c_wb_read: cover property (@(posedge clk_i) disable iff (rst_i) ack_o && !we_i);

endmodule

// ===== pps_pump_model.sv
// Behavioural pump motor, direction relay and optical revolution sensor
`timescale 1ns/10ps

module pps_pump_model #(
  parameter int PER = 8,
  parameter int FILL_N = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Drive from the sequencer
  input wire logic dir_fwd_i,
  input wire logic run_i,
  input wire logic pwr_i,
  // Sensor returns
  output logic pulse_o,
  output logic liquid_o
);
  logic [7:0] ph_reg;
  logic [7:0] fwd_reg;
  logic junk_reg;

  // Rotor turns only with motor on; larger PER gives a slow pump
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_reg <= 8'h00;
      fwd_reg <= 8'h00;
      junk_reg <= 1'b0;
    end else begin
      junk_reg <= !junk_reg;
      if (run_i) begin
        ph_reg <= (ph_reg == 8'(PER - 1)) ? 8'h00 : ph_reg + 8'h01;
      end
      if (!dir_fwd_i) begin
        fwd_reg <= 8'h00;
      end else if (run_i && ph_reg == 8'(PER / 2)) begin
        fwd_reg <= fwd_reg + 8'h01;
      end
    end
  end

  assign liquid_o = fwd_reg >= 8'(FILL_N);
  // Unpowered sensor output wanders, so counting it would show
  assign pulse_o = pwr_i ? (ph_reg >= 8'(PER / 2)) : junk_reg;
endmodule

// ===== peristaltic_pump_sequencer_bench.sv
// Self-checking bench for the pump sequencer
`timescale 1ns/10ps

module peristaltic_pump_sequencer_bench;
  typedef struct {logic [7:0] a; logic [31:0] e;} pps_row_t;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, trigger_i, liquid_i, rev_pulse_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic ack_o, done_o, busy_o, direction_relay_o, motor_run_o, sensor_pwr_o;
  logic dq, rq, pq;
  int n_mismatch, compares, stl, rv, dv, nd;
  logic dirs[$];
  pps_row_t rows[6] = '{'{8'h04, 32'h0}, '{8'h08, 32'h0}, '{8'h0C, 32'h0},
                        '{8'h10, 32'h0}, '{8'h14, 32'h0}, '{8'h20, 32'h0}};

  pps_sequencer #(.RELAY_CYC(4), .PURGE_PULSES(3), .PPR(2)) pps_sequencer_inst (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .trigger_i(trigger_i), .done_o(done_o),
    .busy_o(busy_o), .liquid_i(liquid_i), .rev_pulse_i(rev_pulse_i),
    .direction_relay_o(direction_relay_o), .motor_run_o(motor_run_o), .sensor_pwr_o(sensor_pwr_o));
  pps_pump_model pps_pump_model_inst (.clk_i(clk_i), .rst_i(rst_i), .dir_fwd_i(direction_relay_o),
    .run_i(motor_run_o), .pwr_i(sensor_pwr_o), .pulse_o(rev_pulse_i), .liquid_o(liquid_i));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    // Slave answers in its own time; only the watchdog ends a hung wait
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic run_event();
    int n;
    n = 0;
    rv = 0;
    dv = 0;
    nd = 0;
    dirs.delete();
    while (!(nd > 0 && busy_o === 1'b0) && n < 4000) begin
      n++;
      @(posedge clk_i);
      // Second trigger lands mid-delivery and must be ignored
      trigger_i <= (n == 30) || (n == 100);
    end
  endtask

  // ****************************************
  // Pump-side monitor
  // ****************************************
  always @(posedge clk_i) begin
    stl = (direction_relay_o !== dq) ? 0 : stl + 1;
    if (!rst_i) begin
      chk("sensor_pwr", motor_run_o, sensor_pwr_o);
      if (motor_run_o && !rq) begin
        chk("settle", 1, stl >= 4);
        dirs.push_back(direction_relay_o);
      end
      if (motor_run_o && rq && direction_relay_o !== dq) chk("dir_under_power", dq, direction_relay_o);
      // First powered cycle skipped: a waking sensor is no disk pulse
      if (rev_pulse_i && !pq && motor_run_o && rq) begin
        if (!direction_relay_o) rv++;
        else if (liquid_i) dv++;
      end
      nd += (done_o === 1'b1);
    end
    dq = direction_relay_o;
    rq = motor_run_o;
    pq = rev_pulse_i;
  end

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = !clk_i;
  end

  // Watchdog well beyond three events
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  initial begin
    {rst_i, cyc_i, stb_i, we_i, trigger_i} = 5'b10000;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("reset_outs", 3'b000, {direction_relay_o, motor_run_o, busy_o});
    @(posedge clk_i);
    // Register reset values and unmapped read
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 32'h0, 4'hF);
      chk("reg_read", rows[i].e, q);
    end
    wb(1'b1, 8'h04, 32'h0000_0003, 4'hF);
    wb(1'b1, 8'h04, 32'hAB00_0003, 4'h1);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk("vol", 32'h0000_0003, q);
    // Event by pin, second trigger mid-event must be ignored
    run_event();
    chk("first_dir", 1'b0, dirs[0]);
    chk("fill_dir", 1'b1, dirs[1]);
    chk("last_dir", 1'b0, dirs[$]);
    chk("purge_pulses", 6, rv);
    chk("dlv_pulses", 10, dv);
    chk("done_count", 1, nd);
    wb(1'b0, 8'h0C, 32'h0, 4'hF);
    chk("fill_revs", 32'h0000_0002, q);
    wb(1'b0, 8'h10, 32'h0, 4'hF);
    chk("dlv_target", 32'h0000_000A, q);
    wb(1'b0, 8'h14, 32'h0, 4'hF);
    chk("tot_pulses", 32'h0000_0014, q);
    repeat (50) @(posedge clk_i);
    chk("stays_idle", 2'b00, {busy_o, motor_run_o});
    // Event by register write
    wb(1'b1, 8'h00, 32'h0000_0001, 4'h1);
    wb(1'b0, 8'h08, 32'h0, 4'hF);
    chk("stat_pre_purge", 32'h0000_0011, q);
    nd = 0;
    run_event();
    chk("reg_event_done", 1, nd);
    // Reset in mid-event
    trigger_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    rst_i <= 1'b1;
    trigger_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("mid_reset", 4'b0000, {direction_relay_o, motor_run_o, sensor_pwr_o, busy_o});
    close_out();
  end
endmodule
